// ==== window_watchdog.sv ====
`timescale 1ns/100ps
`include "wdog_params.svh"
module window_watchdog #(
   parameter logic [15:0] POWER_UP_HOLD = `WDOG_POWER_UP_HOLD_CYC,
   parameter logic [15:0] SYNC_TIMEOUT = `WDOG_SYNC_TIMEOUT_CYC,
   parameter logic [15:0] SHORT_CLOSED = `WDOG_SHORT_CLOSED_CYC, // R23
   parameter logic [15:0] SHORT_OPEN = `WDOG_SHORT_OPEN_CYC,
   parameter logic [15:0] LONG_CLOSED = `WDOG_LONG_CLOSED_CYC,
   parameter logic [15:0] LONG_OPEN = `WDOG_LONG_OPEN_CYC,
   parameter logic [15:0] RESET_PULSE = `WDOG_RESET_PULSE_CYC,
   parameter logic [7:0] ALIVE_PULSE_INPUT_MAX = `WDOG_ALIVE_PULSE_INPUT_MAX_CYC,
   parameter int unsigned PIN_DEBOUNCE = `WDOG_PIN_DEBOUNCE_CYC,
   parameter int unsigned WAKE_DEBOUNCE = `WDOG_WAKE_DEBOUNCE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic alive_pulse_input_i,
   input wire logic mode_i,
   input wire logic wake_i,
   input wire logic mcu_rst_i,
   output logic mcu_rst_o,
   output logic mcu_rst_oe_o,
   output logic safe_state_release_out_o
);
   ////////////////////////////////////////////////////////////////////////
   // Input conditioning

   level_filter_if alive_pulse_input_if ();
   level_filter_if mode_if ();
   level_filter_if wake_if ();

   assign alive_pulse_input_if.raw = alive_pulse_input_i;
   assign mode_if.raw = mode_i;
   assign wake_if.raw = wake_i;

   // Pull-up pins idle high, pull-down wake idles low
   level_filter #(.STABLE_CYCLES(PIN_DEBOUNCE), .INIT_LEVEL(1'b1)) u_alive_pulse_input_filt ( // R25
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lf(alive_pulse_input_if)
   );
   level_filter #(.STABLE_CYCLES(PIN_DEBOUNCE), .INIT_LEVEL(1'b1)) u_mode_filt ( // R25
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lf(mode_if)
   );
   level_filter #(.STABLE_CYCLES(WAKE_DEBOUNCE), .INIT_LEVEL(1'b0)) u_wake_filt ( // R18
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lf(wake_if)
   );

   ////////////////////////////////////////////////////////////////////////
   // Phase timing

   wdog_pkg::wdog_state_t state_q;
   wdog_pkg::wdog_state_t state_d;
   logic [15:0] timer_q;
   logic [7:0] low_cnt_q;
   logic [1:0] good_cnt_q;
   logic [1:0] good_cnt_d;
   logic alive_pulse_input_prev_q;
   logic release_q;
   logic rst_oe_q;

   function automatic logic [15:0] phase_len(input wdog_pkg::wdog_state_t st);
      case (st)
         wdog_pkg::ST_POWER_UP: phase_len = POWER_UP_HOLD;
         wdog_pkg::ST_SYNC: phase_len = SYNC_TIMEOUT;
         wdog_pkg::ST_RST_PULSE: phase_len = RESET_PULSE;
         wdog_pkg::ST_SHORT_CLOSE: phase_len = SHORT_CLOSED;
         wdog_pkg::ST_SHORT_OPEN: phase_len = SHORT_OPEN;
         wdog_pkg::ST_LONG_CLOSE: phase_len = LONG_CLOSED;
         wdog_pkg::ST_LONG_OPEN: phase_len = LONG_OPEN;
         default: phase_len = RESET_PULSE;
      endcase
   endfunction

   // Every phase is measured in timebase cycles by one timer
   wire expired = timer_q == (phase_len(state_q) - 16'h0001); // R01
   wire alive_pulse_input_lvl = alive_pulse_input_if.level;
   wire alive_pulse_input_rise = alive_pulse_input_lvl && !alive_pulse_input_prev_q;
   wire in_short = (state_q == wdog_pkg::ST_SHORT_CLOSE) || (state_q == wdog_pkg::ST_SHORT_OPEN);
   wire in_long = (state_q == wdog_pkg::ST_LONG_CLOSE) || (state_q == wdog_pkg::ST_LONG_OPEN);
   wire in_closed = (state_q == wdog_pkg::ST_SHORT_CLOSE) || (state_q == wdog_pkg::ST_LONG_CLOSE);
   wire in_open = (state_q == wdog_pkg::ST_SHORT_OPEN) || (state_q == wdog_pkg::ST_LONG_OPEN);
   wire monitoring = in_short || in_long;

   // A pulse of exactly ALIVE_PULSE_INPUT_MAX low cycles is still legal; only a further low sample is an error
   wire err_overlong = monitoring && !alive_pulse_input_lvl && (low_cnt_q == ALIVE_PULSE_INPUT_MAX); // R08 R20
   wire err_early = in_closed && alive_pulse_input_rise; // R09
   wire err_missing = in_open && expired && !alive_pulse_input_rise; // R10
   wire alive_pulse_input_err = err_overlong || err_early || err_missing; // R24
   wire alive_pulse_input_good = in_open && alive_pulse_input_rise && !err_overlong; // R07
   wire wake_evt = in_long && wake_if.changed; // R18

   ////////////////////////////////////////////////////////////////////////
   // State machine

   always_comb begin
      state_d = state_q;
      case (state_q)
         wdog_pkg::ST_POWER_UP: begin
            if (expired) begin
               state_d = wdog_pkg::ST_SYNC; // R03
            end
         end
         wdog_pkg::ST_SYNC: begin
            // Mode low before timeout enters monitoring
            if (!mode_if.level) begin
               state_d = wdog_pkg::ST_SHORT_CLOSE;
            end else if (expired) begin
               state_d = wdog_pkg::ST_RST_PULSE; // R05 R21
            end
         end
         wdog_pkg::ST_RST_PULSE: begin
            if (expired) begin
               state_d = wdog_pkg::ST_SYNC; // R06
            end
         end
         wdog_pkg::ST_SHORT_CLOSE,
         wdog_pkg::ST_SHORT_OPEN: begin
            if (alive_pulse_input_err) begin
               state_d = wdog_pkg::ST_RST_PULSE;
            end else if (mode_if.level) begin
               state_d = wdog_pkg::ST_LONG_CLOSE; // R14
            end else if (alive_pulse_input_good) begin
               state_d = wdog_pkg::ST_SHORT_CLOSE; // R11
            end else if (expired) begin
               state_d = wdog_pkg::ST_SHORT_OPEN; // R07
            end
         end
         wdog_pkg::ST_LONG_CLOSE,
         wdog_pkg::ST_LONG_OPEN: begin
            // Wake outranks everything so a sleeping host always wakes
            if (wake_evt || alive_pulse_input_err) begin
               state_d = wdog_pkg::ST_RST_PULSE; // R17 R24
            end else if (!mode_if.level) begin
               state_d = wdog_pkg::ST_SHORT_CLOSE; // R19
            end else if (alive_pulse_input_good) begin
               state_d = wdog_pkg::ST_LONG_CLOSE; // R15
            end else if (expired) begin
               state_d = wdog_pkg::ST_LONG_OPEN; // R15
            end
         end
         default: state_d = wdog_pkg::ST_POWER_UP;
      endcase
   end

   wire state_change = state_d != state_q;

   // Good count saturates at the release threshold
   always_comb begin
      good_cnt_d = good_cnt_q;
      if (alive_pulse_input_err || !in_short || state_d == wdog_pkg::ST_LONG_CLOSE) begin
         good_cnt_d = 2'h0; // R13
      end else if (alive_pulse_input_good && good_cnt_q != `WDOG_GOOD_ALIVE_PULSE_INPUT_NEEDED) begin
         good_cnt_d = good_cnt_q + 2'h1; // R12
      end
   end

   wire release_d = in_short && (state_d == wdog_pkg::ST_SHORT_CLOSE || state_d == wdog_pkg::ST_SHORT_OPEN)
      && (good_cnt_d == `WDOG_GOOD_ALIVE_PULSE_INPUT_NEEDED); // R12 R16
   wire rst_oe_d = (state_d == wdog_pkg::ST_POWER_UP) || (state_d == wdog_pkg::ST_RST_PULSE);

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Supply monitor reset lands here; it pulls the reset pin at the next clock edge
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= wdog_pkg::ST_POWER_UP; // R02
         timer_q <= 16'h0000;
         low_cnt_q <= 8'h00;
         good_cnt_q <= 2'h0;
         alive_pulse_input_prev_q <= 1'b1;
         release_q <= 1'b0;
         rst_oe_q <= 1'b1; // R02
      end else begin
         state_q <= state_d;
         timer_q <= state_change ? 16'h0000 : timer_q + 16'h0001; // R22
         alive_pulse_input_prev_q <= alive_pulse_input_lvl;
         good_cnt_q <= good_cnt_d;
         release_q <= release_d;
         rst_oe_q <= rst_oe_d; // R03
         if (alive_pulse_input_lvl || !monitoring) begin
            low_cnt_q <= 8'h00;
         end else if (low_cnt_q != ALIVE_PULSE_INPUT_MAX) begin
            low_cnt_q <= low_cnt_q + 8'h01; // R20
         end
      end
   end

   // Open drain: only ever pulls low
   assign mcu_rst_o = 1'b0;
   assign mcu_rst_oe_o = rst_oe_q;
   assign safe_state_release_out_o = release_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_pulse_starts;
      state_q == wdog_pkg::ST_RST_PULSE ##1 mcu_rst_oe_o;
   endsequence

   property p_power_up_hold;
      $past(state_q) == wdog_pkg::ST_POWER_UP && state_q == wdog_pkg::ST_POWER_UP |-> mcu_rst_oe_o;
   endproperty
   a_power_up_hold: assert property (p_power_up_hold) else $error("reset released during power-up hold"); // R03

   property p_sync_timeout;
      state_q == wdog_pkg::ST_SYNC && expired && mode_if.level |=> s_pulse_starts;
   endproperty
   a_sync_timeout: assert property (p_sync_timeout) else $error("sync timeout gave no reset pulse"); // R05

   property p_pulse_to_sync;
      state_q == wdog_pkg::ST_RST_PULSE && expired |=> state_q == wdog_pkg::ST_SYNC ##1 !mcu_rst_oe_o;
   endproperty
   a_pulse_to_sync: assert property (p_pulse_to_sync) else $error("reset pulse not followed by sync"); // R06

   property p_early_trigger;
      in_short && in_closed && alive_pulse_input_rise |=> s_pulse_starts;
   endproperty
   a_early_trigger: assert property (p_early_trigger) else $error("early trigger not punished"); // R09

   property p_missing_trigger;
      in_open && expired && !alive_pulse_input_rise |=> state_q == wdog_pkg::ST_RST_PULSE;
   endproperty
   a_missing_trigger: assert property (p_missing_trigger) else $error("missing trigger not punished"); // R10

   property p_overlong;
      monitoring && low_cnt_q == ALIVE_PULSE_INPUT_MAX && !alive_pulse_input_lvl && !wake_evt |=> state_q == wdog_pkg::ST_RST_PULSE;
   endproperty
   a_overlong: assert property (p_overlong) else $error("overlong trigger not punished"); // R20

   property p_release_needs_three;
      $rose(safe_state_release_out_o) |-> good_cnt_q == `WDOG_GOOD_ALIVE_PULSE_INPUT_NEEDED;
   endproperty
   a_release_needs_three: assert property (p_release_needs_three) else $error("release before three triggers"); // R12

   property p_error_drops_release;
      alive_pulse_input_err |=> !safe_state_release_out_o && good_cnt_q == 2'h0;
   endproperty
   a_error_drops_release: assert property (p_error_drops_release) else $error("error kept release"); // R13

   property p_long_no_release;
      in_long && $past(in_long) |-> !safe_state_release_out_o;
   endproperty
   a_long_no_release: assert property (p_long_no_release) else $error("release active in long mode"); // R16

   property p_wake;
      wake_evt |=> s_pulse_starts;
   endproperty
   a_wake: assert property (p_wake) else $error("wake event gave no reset pulse"); // R17

   property p_timer_restart;
      state_q != $past(state_q) |-> timer_q == 16'h0000;
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted on state change"); // R22
endmodule

// ==== wdog_params.svh ====
// Functional notes
// R01: All durations count cycles of the one timebase clock.
// R02: Power-on reset puts all state at its initial value and pulses reset.
// R03: After power-up the reset output stays asserted for the power-up hold time.
// R04: Microcontroller drives mode low before the sync timeout ends.
// R05: Mode still high at sync timeout gives a reset pulse and restarts the timeout.
// R06: Every reset pulse is followed by a fresh switch-over phase.
// R07: After switch-over, short window mode accepts triggers only in the open phase.
// R08: Short window: overlong trigger pulse gives a reset pulse.
// R09: Short window: trigger in the closed phase gives a reset pulse.
// R10: Short window: open phase ending with no trigger gives a reset pulse.
// R11: Rising edge of a valid trigger starts a new cycle at the closed phase.
// R12: Release output asserts only after three consecutive correct triggers.
// R13: Any bad trigger drops the release output and clears the good count.
// R14: Mode high switches short window monitoring to long window monitoring.
// R15: Long window mode has its own longer closed phase and its own open phase.
// R16: Release output stays inactive throughout long window mode.
// R17: Wake event in long mode gives a reset pulse and restarts switch-over.
// R18: Wake input is debounced; either edge counts as a wake event in long mode.
// R19: Mode low in long window mode returns to short window monitoring.
// R20: Trigger low for longer than 45 cycles is a trigger error.
// R21: Sync timeout lasts 1112 cycles.
// R22: Every state change restarts the single phase timer.
// R23: Phase lengths and reset pulse width are cycle-count parameters.
// R24: Long mode treats early, overlong and missing triggers like short mode.
// R25: Trigger and mode inputs are synchronised and debounced before use.
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH

`define WDOG_POWER_UP_HOLD_CYC 16'h00C9
`define WDOG_SYNC_TIMEOUT_CYC 16'h0458
`define WDOG_ALIVE_PULSE_INPUT_MAX_CYC 8'h2D
`define WDOG_SHORT_CLOSED_CYC 16'h00C8
`define WDOG_SHORT_OPEN_CYC 16'h00C8
`define WDOG_LONG_CLOSED_CYC 16'h1F40
`define WDOG_LONG_OPEN_CYC 16'h07D0
`define WDOG_RESET_PULSE_CYC 16'h0028
`define WDOG_PIN_DEBOUNCE_CYC 3
`define WDOG_WAKE_DEBOUNCE_CYC 96
`define WDOG_GOOD_ALIVE_PULSE_INPUT_NEEDED 2'h3

`endif

// ==== wdog_pkg.sv ====
package wdog_pkg;
   typedef enum logic [2:0] {
      ST_POWER_UP    = 3'h0,
      ST_SYNC        = 3'h1,
      ST_RST_PULSE   = 3'h2,
      ST_SHORT_CLOSE = 3'h3,
      ST_SHORT_OPEN  = 3'h4,
      ST_LONG_CLOSE  = 3'h5,
      ST_LONG_OPEN   = 3'h6
   } wdog_state_t;
endpackage

// ==== level_filter_if.sv ====
`timescale 1ns/100ps
interface level_filter_if;
   logic raw;
   logic level;
   logic changed;
   modport filt (input raw, output level, output changed);
   modport user (output raw, input level, input changed);
endinterface

// ==== level_filter.sv ====
`timescale 1ns/100ps
module level_filter #(
   parameter int unsigned STABLE_CYCLES = 3,
   parameter logic INIT_LEVEL = 1'b0
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   level_filter_if.filt lf
);
   localparam int unsigned CW = $clog2(STABLE_CYCLES) + 1;
   localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

   logic sync1_q;
   logic sync2_q;
   logic level_q;
   logic changed_q;
   logic [CW-1:0] cnt_q;

   wire differs = sync2_q != level_q;
   wire settled = differs && (cnt_q == LAST);

   // Pin crosses two flops, then must differ for STABLE_CYCLES samples
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sync1_q <= INIT_LEVEL;
         sync2_q <= INIT_LEVEL;
         level_q <= INIT_LEVEL;
         changed_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         sync1_q <= lf.raw;
         sync2_q <= sync1_q;
         changed_q <= settled;
         if (!differs || settled) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + CW'(1);
         end
         if (settled) begin
            level_q <= sync2_q;
         end
      end
   end

   assign lf.level = level_q;
   assign lf.changed = changed_q;
endmodule

// ==== mcu_model.sv ====
`timescale 1ns/100ps
module mcu_model (
   input wire logic clk_sys_i,
   input wire logic rst_pin_i,
   output logic alive_pulse_input_o,
   output logic mode_o
);
   initial begin
      alive_pulse_input_o = 1'b1;
      mode_o = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode pin: low enters short window, high enters long window
   task automatic set_mode(input logic v);
      @(posedge clk_sys_i);
      mode_o <= v;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Low pulse after a chosen delay; a held reset pin ends it, as a real core stops
   task automatic pulse(input int wait_cyc, input int low_cyc, output int held);
      held = 0;
      repeat (wait_cyc) @(posedge clk_sys_i);
      alive_pulse_input_o <= 1'b0;
      while (held < low_cyc && rst_pin_i === 1'b1) begin
         @(posedge clk_sys_i);
         held++;
      end
      alive_pulse_input_o <= 1'b1;
   endtask
endmodule

// ==== window_watchdog_sleep_wake_tb.sv ====
`timescale 1ns/100ps
`include "wdog_params.svh"
module window_watchdog_sleep_wake_tb;
   logic clk_sys_i;
   logic sys_rst_i;
   logic wake_i;
   logic alive_pulse_input_w;
   logic mode_w;
   logic mcu_rst_o;
   logic mcu_rst_oe_o;
   logic safe_state_release_out_o;
   logic rst_seen;
   wire logic rst_pin;
   int fails;
   int samples_checked;
   int cyc;
   int n;
   int held;

   // Open-drain reset pin with pull-up
   assign rst_pin = mcu_rst_oe_o ? mcu_rst_o : 1'b1;

   // Documented phase lengths; the long closed phase alone costs some eight thousand cycles
   window_watchdog DUT (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .alive_pulse_input_i(alive_pulse_input_w),
      .mode_i(mode_w),
      .wake_i(wake_i),
      .mcu_rst_i(rst_pin),
      .mcu_rst_o(mcu_rst_o),
      .mcu_rst_oe_o(mcu_rst_oe_o),
      .safe_state_release_out_o(safe_state_release_out_o)
   );

   mcu_model mcu (
      .clk_sys_i(clk_sys_i),
      .rst_pin_i(rst_pin),
      .alive_pulse_input_o(alive_pulse_input_w),
      .mode_o(mode_w)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) if (mcu_rst_oe_o === 1'b1) rst_seen <= 1'b1;

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_range(input string name, input int lo, input int hi, input int got);
      samples_checked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   // Bounded waits on the reset output; n counts the cycles spent
   task automatic wait_oe(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (mcu_rst_oe_o !== lvl && cnt < lim) begin
         @(posedge clk_sys_i);
         cnt++;
      end
      check_bit("reset output level reached", lvl, mcu_rst_oe_o);
   endtask

   task automatic pulse_width();
      int w;
      check_bit("reset pin level during pulse", 1'b0, rst_pin);
      wait_oe(1'b0, 60, w);
      check_range("reset pulse width", `WDOG_RESET_PULSE_CYC, `WDOG_RESET_PULSE_CYC, w);
   endtask

   // Called two edges after a closed phase starts, or up to six edges before it after a mode change or reset pulse, so the rise lands well inside the open phase
   task automatic good_alive_pulse_input(input logic exp_rel, input int low_cyc);
      int h;
      rst_seen = 1'b0;
      mcu.pulse(240, low_cyc, h);
      repeat (8) @(posedge clk_sys_i);
      check_bit("reset after open phase trigger", 1'b0, rst_seen);
      check_bit("release output", exp_rel, safe_state_release_out_o);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_power_up();
      repeat (195) @(posedge clk_sys_i);
      check_bit("reset held at power-up", 1'b1, mcu_rst_oe_o);
      check_bit("release at power-up", 1'b0, safe_state_release_out_o);
      wait_oe(1'b0, 30, n);
      check_range("power-up hold length", `WDOG_POWER_UP_HOLD_CYC + 1, `WDOG_POWER_UP_HOLD_CYC + 1, 195 + n);
   endtask

   task automatic t_sync_timeout();
      wait_oe(1'b1, 1200, n);
      check_range("sync timeout length", `WDOG_SYNC_TIMEOUT_CYC, `WDOG_SYNC_TIMEOUT_CYC, n);
      pulse_width();
   endtask

   task automatic t_short_errors();
      int miss_cyc = `WDOG_SHORT_CLOSED_CYC + `WDOG_SHORT_OPEN_CYC + 1;
      mcu.set_mode(1'b0);
      good_alive_pulse_input(1'b0, 4);
      good_alive_pulse_input(1'b0, 4);
      good_alive_pulse_input(1'b1, 4);
      mcu.pulse(10, 4, held);
      wait_oe(1'b1, 30, n);
      check_bit("release after early trigger", 1'b0, safe_state_release_out_o);
      pulse_width();
      wait_oe(1'b1, 450, n);
      check_range("missing trigger delay", miss_cyc, miss_cyc, n);
      pulse_width();
      mcu.pulse(240, 60, held);
      check_range("overlong trigger low cycles", `WDOG_ALIVE_PULSE_INPUT_MAX_CYC + 5, `WDOG_ALIVE_PULSE_INPUT_MAX_CYC + 8, held);
      pulse_width();
   endtask

   task automatic t_long_mode();
      good_alive_pulse_input(1'b0, 45);
      good_alive_pulse_input(1'b0, 4);
      good_alive_pulse_input(1'b1, 4);
      mcu.set_mode(1'b1);
      repeat (10) @(posedge clk_sys_i);
      check_bit("release in long mode", 1'b0, safe_state_release_out_o);
      rst_seen = 1'b0;
      // Rise lands just after the long closed phase ends
      mcu.pulse(8200, 4, held);
      repeat (8) @(posedge clk_sys_i);
      check_bit("reset after long open trigger", 1'b0, rst_seen);
      mcu.set_mode(1'b0);
      good_alive_pulse_input(1'b0, 4);
      mcu.set_mode(1'b1);
      repeat (10) @(posedge clk_sys_i);
      wake_i <= 1'b1;
      wait_oe(1'b1, 130, n);
      check_range("wake debounce delay", `WDOG_WAKE_DEBOUNCE_CYC, `WDOG_WAKE_DEBOUNCE_CYC + 8, n);
      pulse_width();
      // Falling wake edge must wake the host as well
      mcu.set_mode(1'b0);
      repeat (10) @(posedge clk_sys_i);
      mcu.set_mode(1'b1);
      repeat (10) @(posedge clk_sys_i);
      wake_i <= 1'b0;
      wait_oe(1'b1, 130, n);
      check_range("wake falling edge delay", `WDOG_WAKE_DEBOUNCE_CYC, `WDOG_WAKE_DEBOUNCE_CYC + 8, n);
      pulse_width();
   endtask

   task automatic t_mid_reset();
      mcu.set_mode(1'b0);
      good_alive_pulse_input(1'b0, 4);
      good_alive_pulse_input(1'b0, 4);
      good_alive_pulse_input(1'b1, 4);
      repeat (20) @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      check_bit("reset output under supply reset", 1'b1, mcu_rst_oe_o);
      check_bit("release under supply reset", 1'b0, safe_state_release_out_o);
      sys_rst_i <= 1'b0;
      repeat (100) @(posedge clk_sys_i);
      check_bit("power-up hold after supply reset", 1'b1, mcu_rst_oe_o);
      wait_oe(1'b0, 150, n);
      check_range("hold after supply reset", `WDOG_POWER_UP_HOLD_CYC - 99, `WDOG_POWER_UP_HOLD_CYC - 99, n);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst_i = 1'b1;
      wake_i = 1'b0;
      rst_seen = 1'b0;
      fails = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_power_up();
      t_sync_timeout();
      t_short_errors();
      t_long_mode();
      t_mid_reset();
      print_verdict();
   end
endmodule
